// ==== rtl/srs_consts.svh ====
// constants for the switch reset and initialization sequencer
`ifndef SRS_CONSTS_SVH
`define SRS_CONSTS_SVH
`define SRS_CLK_MHZ          100
`define SRS_TRAIN_MS         20
`define SRS_CFG_READY_MS     100
`define SRS_TRAIN_CYC        (`SRS_TRAIN_MS * 1000 * `SRS_CLK_MHZ)
`define SRS_CFG_READY_CYC    (`SRS_CFG_READY_MS * 1000 * `SRS_CLK_MHZ)
`define SRS_MODE_NORMAL      3'h0
`define SRS_MODE_EEPROM      3'h1
`define SRS_NPORTS           6
`define SRS_ADDR_CTRL        12'h000
`define SRS_ADDR_STATUS      12'h004
`define SRS_ADDR_SMBSTS      12'h008
`define SRS_ADDR_LINKSTS     12'h00C
`define SRS_ADDR_PHYSTATE    12'h010
`define SRS_CTRL_FUNDAMENTAL_RESET_CTL_BIT_BIT    0
`define SRS_CTRL_HRST_BIT    1
`define SRS_SMB_DONE_BIT     0
`define SRS_SMB_ERR_BIT      1
`define SRS_RESP_OKAY        2'h0
`define SRS_RESP_SLVERR      2'h2
`endif

// ==== rtl/srs_pkg.sv ====
// types of the switch reset and initialization sequencer
`default_nettype none
package srs_pkg;
  typedef enum logic [3:0] {
    SRS_ST_HOLD     = 4'h0,
    SRS_ST_MODE     = 4'h1,
    SRS_ST_PLL      = 4'h2,
    SRS_ST_TRAIN    = 4'h3,
    SRS_ST_SPEED    = 4'h4,
    SRS_ST_SSMB     = 4'h5,
    SRS_ST_MSMB     = 4'h6,
    SRS_ST_EEPROM   = 4'h7,
    SRS_ST_RUN      = 4'h8,
    SRS_ST_WARM     = 4'h9
  } srs_state_t;
endpackage : srs_pkg
`default_nettype wire

// ==== rtl/srs_sequencer.sv ====
// reset and initialization sequencer with axi4-lite registers
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`include "srs_consts.svh"
`default_nettype none
module srs_sequencer
  import srs_pkg::*;
#(
  parameter int unsigned TRAIN_CYC     = `SRS_TRAIN_CYC,
  parameter int unsigned CFG_READY_CYC = `SRS_CFG_READY_CYC
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        fundamental_reset_n,
  input  wire logic        common_clock_downstream,
  input  wire logic        common_clock_upstream,
  input  wire logic [2:0]  operating_mode_sel,
  input  wire logic        master_smbus_slow_sel,
  input  wire logic [3:0]  slave_smbus_addr_straps,
  input  wire logic        pll_locked,
  input  wire logic        ee_wr_valid,
  input  wire logic [11:0] ee_wr_addr,
  input  wire logic [31:0] ee_wr_data,
  input  wire logic        ee_error,
  input  wire logic [7:0]  ee_error_code,
  input  wire logic        ee_last,
  input  wire logic        hot_reset_req,
  input  wire logic        us_sbr_req,
  input  wire logic [4:0]  ds_sbr_req,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             core_reset_n,
  output logic             pll_reset_n,
  output logic             link_train_en,
  output logic             quasi_reset,
  output logic             cfg_retry,
  output logic             msmb_slow,
  output logic             ssmb_enable,
  output logic [3:0]       ssmb_addr,
  output logic             msmb_enable,
  output logic             ee_load_en,
  output logic [5:0]       retrain_pulse,
  output logic [5:0]       port_hot_reset
);

  srs_state_t  st_q;
  srs_state_t  st_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        pin_q;
  logic        pin_d;
  logic        cap_ds_q;
  logic        cap_ds_d;
  logic        cap_us_q;
  logic        cap_us_d;
  logic [2:0]  cap_mode_q;
  logic [2:0]  cap_mode_d;
  logic        slow_q;
  logic        slow_d;
  logic [3:0]  addr_q;
  logic [3:0]  addr_d;
  logic [5:0]  sclk_q;
  logic [5:0]  sclk_d;
  logic        ee_done_q;
  logic        ee_done_d;
  logic        ee_err_q;
  logic        ee_err_d;
  logic [7:0]  ee_code_q;
  logic [7:0]  ee_code_d;
  logic        warm_q;
  logic        warm_d;
  logic        aw_q;
  logic        aw_d;
  logic        w_q;
  logic        w_d;
  logic        bv_q;
  logic        bv_d;
  logic        rv_q;
  logic        rv_d;
  logic [11:0] awa_q;
  logic [11:0] awa_d;
  logic [31:0] wd_q;
  logic [31:0] wd_d;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  logic [1:0]  br_q;
  logic [1:0]  br_d;
  logic [1:0]  rr_q;
  logic [1:0]  rr_d;
  logic [5:0]  rt_q;
  logic [5:0]  rt_d;
  logic        sw_wr;
  logic        ee_sel;

  assign sw_wr  = aw_q && w_q && !bv_q;
  assign ee_sel = (cap_mode_q == `SRS_MODE_EEPROM);

  // sequencer and boot capture
  always_comb begin
    st_d       = st_q;
    cnt_d      = (cnt_q == 32'hFFFFFFFF) ? cnt_q : cnt_q + 32'h1;
    pin_d      = pin_q;
    cap_ds_d   = cap_ds_q;
    cap_us_d   = cap_us_q;
    cap_mode_d = cap_mode_q;
    slow_d     = slow_q;
    addr_d     = addr_q;
    sclk_d     = sclk_q;
    ee_done_d  = ee_done_q;
    ee_err_d   = ee_err_q;
    ee_code_d  = ee_code_q;
    warm_d     = warm_q;
    rt_d       = 6'h00;
    if (!fundamental_reset_n) begin
      st_d  = SRS_ST_HOLD;
      pin_d = 1'b1;
    end else begin
      unique case (st_q)
        SRS_ST_HOLD: begin
          if (pin_q) begin
            cap_ds_d   = common_clock_downstream;
            cap_us_d   = common_clock_upstream;
            cap_mode_d = operating_mode_sel;
            // speed and address straps are boot straps too, kept on warm reset
            slow_d     = master_smbus_slow_sel;
            addr_d     = slave_smbus_addr_straps;
          end
          pin_d     = 1'b0;
          cnt_d     = 32'h0;
          ee_done_d = 1'b0;
          ee_err_d  = 1'b0;
          ee_code_d = 8'h00;
          st_d      = SRS_ST_MODE;
        end
        SRS_ST_MODE: begin
          sclk_d = {{(`SRS_NPORTS-1){cap_ds_q}}, cap_us_q};
          st_d   = SRS_ST_PLL;
        end
        SRS_ST_PLL:    if (pll_locked) st_d = SRS_ST_TRAIN;
        SRS_ST_TRAIN:  st_d = SRS_ST_SPEED;
        SRS_ST_SPEED: begin
          st_d = SRS_ST_SSMB;
        end
        SRS_ST_SSMB: begin
          st_d = SRS_ST_MSMB;
        end
        SRS_ST_MSMB: st_d = ee_sel ? SRS_ST_EEPROM : SRS_ST_RUN;
        SRS_ST_EEPROM: begin
          if (ee_error) begin
            ee_err_d  = 1'b1;
            ee_code_d = ee_error_code;
            ee_done_d = 1'b1;
            st_d      = SRS_ST_RUN;
          end else if (ee_wr_valid) begin
            if (ee_wr_addr == `SRS_ADDR_PHYSTATE)
              rt_d = ee_wr_data[5:0];
            if (ee_wr_addr == `SRS_ADDR_LINKSTS)
              sclk_d = ee_wr_data[5:0];
            if (ee_last) begin
              ee_done_d = 1'b1;
              st_d      = SRS_ST_RUN;
            end
          end
        end
        SRS_ST_RUN: begin
          if (sw_wr && awa_q == `SRS_ADDR_LINKSTS)
            sclk_d = wd_q[5:0];
          if (sw_wr && awa_q == `SRS_ADDR_PHYSTATE)
            rt_d = wd_q[5:0];
          if (sw_wr && awa_q == `SRS_ADDR_CTRL && wd_q[`SRS_CTRL_FUNDAMENTAL_RESET_CTL_BIT_BIT])
            warm_d = 1'b1;
          if (warm_q && bv_q && s_axi_bready) begin
            warm_d = 1'b0;
            st_d   = SRS_ST_WARM;
          end
        end
        SRS_ST_WARM: st_d = SRS_ST_HOLD;
        default:     st_d = SRS_ST_HOLD;
      endcase
    end
  end

  // axi4-lite slave
  always_comb begin
    aw_d  = aw_q;
    w_d   = w_q;
    awa_d = awa_q;
    wd_d  = wd_q;
    bv_d  = bv_q;
    br_d  = br_q;
    rv_d  = rv_q;
    rd_d  = rd_q;
    rr_d  = rr_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d  = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d  = 1'b1;
      wd_d = s_axi_wdata;
    end
    if (sw_wr) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      bv_d = 1'b1;
      br_d = (awa_q == `SRS_ADDR_CTRL || awa_q == `SRS_ADDR_LINKSTS ||
              awa_q == `SRS_ADDR_PHYSTATE || awa_q == `SRS_ADDR_STATUS ||
              awa_q == `SRS_ADDR_SMBSTS) ? `SRS_RESP_OKAY : `SRS_RESP_SLVERR;
    end
    if (bv_q && s_axi_bready)
      bv_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rv_d = 1'b1;
      rr_d = `SRS_RESP_OKAY;
      unique case (s_axi_araddr)
        `SRS_ADDR_CTRL:     rd_d = {31'h0, warm_q};
        `SRS_ADDR_STATUS:   rd_d = {26'h0, cap_mode_q, cap_us_q, cap_ds_q, slow_q};
        `SRS_ADDR_SMBSTS:   rd_d = {22'h0, ee_code_q, ee_err_q, ee_done_q};
        `SRS_ADDR_LINKSTS:  rd_d = {26'h0, sclk_q};
        `SRS_ADDR_PHYSTATE: rd_d = {28'h0, st_q};
        default: begin
          rd_d = 32'h0;
          rr_d = `SRS_RESP_SLVERR;
        end
      endcase
    end
    if (rv_q && s_axi_rready)
      rv_d = 1'b0;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q       <= SRS_ST_HOLD;
      cnt_q      <= 32'h0;
      pin_q      <= 1'b1;
      cap_ds_q   <= 1'b0;
      cap_us_q   <= 1'b0;
      cap_mode_q <= `SRS_MODE_NORMAL;
      slow_q     <= 1'b0;
      addr_q     <= 4'h0;
      sclk_q     <= 6'h00;
      ee_done_q  <= 1'b0;
      ee_err_q   <= 1'b0;
      ee_code_q  <= 8'h00;
      warm_q     <= 1'b0;
      rt_q       <= 6'h00;
      aw_q       <= 1'b0;
      w_q        <= 1'b0;
      awa_q      <= 12'h000;
      wd_q       <= 32'h0;
      bv_q       <= 1'b0;
      br_q       <= 2'h0;
      rv_q       <= 1'b0;
      rd_q       <= 32'h0;
      rr_q       <= 2'h0;
    end else begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      pin_q      <= pin_d;
      cap_ds_q   <= cap_ds_d;
      cap_us_q   <= cap_us_d;
      cap_mode_q <= cap_mode_d;
      slow_q     <= slow_d;
      addr_q     <= addr_d;
      sclk_q     <= sclk_d;
      ee_done_q  <= ee_done_d;
      ee_err_q   <= ee_err_d;
      ee_code_q  <= ee_code_d;
      warm_q     <= warm_d;
      rt_q       <= rt_d;
      aw_q       <= aw_d;
      w_q        <= w_d;
      awa_q      <= awa_d;
      wd_q       <= wd_d;
      bv_q       <= bv_d;
      br_q       <= br_d;
      rv_q       <= rv_d;
      rd_q       <= rd_d;
      rr_q       <= rr_d;
    end
  end

  assign s_axi_awready = !aw_q && !bv_q;
  assign s_axi_wready  = !w_q && !bv_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;

  logic past_pll;
  logic past_train;
  assign past_pll   = (st_q != SRS_ST_HOLD) && (st_q != SRS_ST_MODE) &&
                      (st_q != SRS_ST_WARM);
  assign past_train = past_pll && (st_q != SRS_ST_PLL);

  assign pll_reset_n   = past_pll || (st_q == SRS_ST_PLL);
  assign core_reset_n  = past_train;
  assign link_train_en = past_train;
  // quasi reset ends once TRAIN_CYC cycles (20ms) have passed since leaving hold, including the pll lock wait
  assign quasi_reset   = past_train && (cnt_q < TRAIN_CYC);
  assign cfg_retry     = past_train && ((st_q == SRS_ST_EEPROM) ||
                         (cnt_q < CFG_READY_CYC) || (st_q != SRS_ST_RUN));
  assign msmb_slow     = slow_q;
  assign ssmb_enable   = (st_q == SRS_ST_MSMB) || (st_q == SRS_ST_EEPROM) ||
                         (st_q == SRS_ST_RUN);
  assign ssmb_addr     = addr_q;
  assign msmb_enable   = (st_q == SRS_ST_EEPROM) || (st_q == SRS_ST_RUN);
  assign ee_load_en    = (st_q == SRS_ST_EEPROM);
  assign retrain_pulse = rt_q;

  // per port hot reset: port 0 on hot reset, others also on bus resets
  genvar gi;
  generate
    for (gi = 0; gi < `SRS_NPORTS; gi++) begin : g_port
      if (gi == 0) begin : g_up
        assign port_hot_reset[gi] = hot_reset_req;
      end else begin : g_dn
        assign port_hot_reset[gi] = hot_reset_req || us_sbr_req ||
                                    ds_sbr_req[gi-1];
      end
    end
  endgenerate

endmodule : srs_sequencer
`default_nettype wire

// ==== tb/srs_sequencer_props.sv ====
// assertions on the sequencer ports
`default_nettype none
module srs_sequencer_props (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        fundamental_reset_n,
  input wire logic        pll_locked,
  input wire logic        ee_wr_valid,
  input wire logic [11:0] ee_wr_addr,
  input wire logic [31:0] ee_wr_data,
  input wire logic        ee_error,
  input wire logic        ee_last,
  input wire logic        us_sbr_req,
  input wire logic [4:0]  ds_sbr_req,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        pll_reset_n,
  input wire logic        link_train_en,
  input wire logic        cfg_retry,
  input wire logic        ssmb_enable,
  input wire logic        msmb_enable,
  input wire logic        ee_load_en,
  input wire logic [5:0]  retrain_pulse,
  input wire logic [5:0]  port_hot_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_hold; !fundamental_reset_n |=> !link_train_en && !msmb_enable && !ee_load_en;
  endproperty
  a_hold: assert property (p_hold) else $error("sequence ran with pin held");
  property p_train; $rose(link_train_en) |-> pll_reset_n && $past(pll_locked); endproperty
  a_train: assert property (p_train) else $error("training before lock");
  property p_smb; $rose(msmb_enable) |-> ssmb_enable && $past(ssmb_enable); endproperty
  a_smb: assert property (p_smb) else $error("master before slave");
  property p_retry; ee_load_en |-> cfg_retry; endproperty
  a_retry: assert property (p_retry) else $error("no retry during load");
  property p_rt;
    ee_load_en && ee_wr_valid && ee_wr_addr == 12'h010 |=> retrain_pulse == $past(ee_wr_data[5:0]);
  endproperty
  a_rt: assert property (p_rt) else $error("retrain pulse wrong");
  property p_done; ee_load_en && (ee_error || ee_wr_valid && ee_last) |-> ##[1:4] !ee_load_en;
  endproperty
  a_done: assert property (p_done) else $error("load did not end");
  property p_ds; (port_hot_reset[5:1] & ds_sbr_req) == ds_sbr_req; endproperty
  a_ds: assert property (p_ds) else $error("port hot reset missing");
  property p_us; us_sbr_req |-> port_hot_reset == 6'h3E; endproperty
  a_us: assert property (p_us) else $error("upstream bus reset wrong");
  property p_b; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_b: assert property (p_b) else $error("write response dropped");
endmodule : srs_sequencer_props
bind srs_sequencer srs_sequencer_props u_srs_sequencer_props (.*);
`default_nettype wire

// ==== tb/srs_ee_model.sv ====
// eeprom side model feeding register writes to the sequencer
`default_nettype none
module srs_ee_model (
  input  wire logic   clk,
  input  wire logic   resetn,
  input  wire logic   ee_load_en,
  input  wire logic   ee_fail,
  output logic        ee_wr_valid,
  output logic [11:0] ee_wr_addr,
  output logic [31:0] ee_wr_data,
  output logic        ee_error,
  output logic [7:0]  ee_error_code,
  output logic        ee_last
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] step_q, step_d;
  always_comb begin
    step_d = ee_load_en ? step_q + {3'h0, step_q != 4'hF} : 4'h0;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) step_q <= 4'h0;
    else step_q <= step_d;
  end
  // slot clock word, then the retrain word or a failure
  always_comb begin
    ee_wr_valid   = ee_load_en && (step_q == 4'h3 || (step_q == 4'h7 && !ee_fail));
    ee_wr_addr    = (step_q == 4'h3) ? 12'h00C : 12'h010;
    ee_wr_data    = ee_wr_valid ? ((step_q == 4'h3) ? 32'h2A : 32'h5) : {8{step_q}};
    ee_last       = ee_wr_valid && step_q == 4'h7;
    ee_error      = ee_load_en && ee_fail && step_q == 4'h7;
    ee_error_code = 8'h5A;
  end
endmodule : srs_ee_model
`default_nettype wire

// ==== tb/test_srs_sequencer.sv ====
// testbench for the reset and initialization sequencer
`default_nettype none
module test_srs_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, resetn = 1'b0, fundamental_reset_n = 1'b0, pll_locked = 1'b0;
  logic common_clock_downstream = 1'b0, common_clock_upstream = 1'b0;
  logic master_smbus_slow_sel = 1'b0, hot_reset_req = 1'b0, us_sbr_req = 1'b0, ee_fail = 1'b0;
  logic [2:0] operating_mode_sel = 3'h0;
  logic [3:0] slave_smbus_addr_straps = 4'h0, s_axi_wstrb = 4'hF, ssmb_addr;
  logic [4:0] ds_sbr_req = 5'h00;
  logic ee_wr_valid, ee_error, ee_last, ee_seen = 1'b0;
  logic [11:0] ee_wr_addr, s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] ee_wr_data, s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [7:0] ee_error_code;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic core_reset_n, pll_reset_n, link_train_en, quasi_reset, cfg_retry, msmb_slow;
  logic ssmb_enable, msmb_enable, ee_load_en;
  logic [5:0] retrain_pulse, port_hot_reset, rt_seen = 6'h00;
  int errors = 0, cmp_count = 0, cycles = 0;
  srs_sequencer #(.TRAIN_CYC(20), .CFG_READY_CYC(50)) u_srs_sequencer (.*);
  srs_ee_model u_srs_ee_model (.*);
  always #5 clk = ~clk;
  task automatic finish_test();
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cycles <= cycles + 1;
    ee_seen <= fundamental_reset_n && (ee_seen || ee_load_en);
    rt_seen <= fundamental_reset_n ? (rt_seen | retrain_pulse) : 6'h00;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw, w;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(negedge clk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      @(posedge clk);
      s_axi_awvalid <= aw;
      s_axi_wvalid  <= w;
    end
    @(negedge clk);
    while (!s_axi_bvalid) @(negedge clk);
    resp = s_axi_bresp;
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input string n);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    @(negedge clk);
    while (!s_axi_arready) @(negedge clk);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    @(negedge clk);
    while (!s_axi_rvalid) @(negedge clk);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'b0;
    chk(n, e, rdat);
  endtask : rc
  task automatic settle();
    @(negedge clk);
    while (!cfg_retry) @(negedge clk);
    while (cfg_retry) @(negedge clk);
  endtask : settle
  task automatic boot(input logic [2:0] m, input logic s, cd, cu, f, input logic [3:0] a);
    @(posedge clk);
    fundamental_reset_n     <= 1'b0;
    pll_locked              <= 1'b0;
    operating_mode_sel      <= m;
    master_smbus_slow_sel   <= s;
    common_clock_downstream <= cd;
    common_clock_upstream   <= cu;
    slave_smbus_addr_straps <= a;
    ee_fail                 <= f;
    repeat (4) @(posedge clk);
    fundamental_reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    pll_locked <= 1'b1;
    @(negedge clk);
    chk("train before lock", 32'h0, {31'h0, link_train_en});
    settle();
    chk("quasi", 32'h0, {31'h0, quasi_reset});
    chk("core rst", 32'h1, {31'h0, core_reset_n});
    chk("slow", {31'h0, s}, {31'h0, msmb_slow});
    chk("saddr", {28'h0, a}, {28'h0, ssmb_addr});
    chk("ee load", {31'h0, m == 3'h1}, {31'h0, ee_seen});
    chk("retrain", (m == 3'h1 && !f) ? 32'h5 : 32'h0, {26'h0, rt_seen});
    rc(12'h004, {26'h0, m, cu, cd, s}, "status");
    rc(12'h00C, (m == 3'h1) ? 32'h2A : {26'h0, {5{cd}}, cu}, "slot clk");
    rc(12'h008, (m == 3'h1) ? (f ? 32'h16B : 32'h1) : 32'h0, "smb sts");
  endtask : boot
  task automatic warm();
    operating_mode_sel    <= 3'h1;
    master_smbus_slow_sel <= 1'b0;
    wr(12'h000, 32'h1);
    chk("warm bresp", 32'h0, {30'h0, resp});
    settle();
    chk("warm ee load", 32'h0, {31'h0, ee_seen});
    rc(12'h004, 32'h3, "kept status");
  endtask : warm
  task automatic misc();
    rc(12'h0FC, 32'h0, "unmapped");
    chk("unmapped resp", 32'h2, {30'h0, resp});
    ds_sbr_req <= 5'h12;
    @(negedge clk);
    chk("ds hot", 32'h24, {26'h0, port_hot_reset});
    @(posedge clk);
    ds_sbr_req <= 5'h00;
    us_sbr_req <= 1'b1;
    @(negedge clk);
    chk("us hot", 32'h3E, {26'h0, port_hot_reset});
    @(posedge clk);
    us_sbr_req    <= 1'b0;
    hot_reset_req <= 1'b1;
    @(negedge clk);
    chk("hot", 32'h3F, {26'h0, port_hot_reset});
    @(posedge clk);
    hot_reset_req <= 1'b0;
  endtask : misc
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    boot(3'h0, 1'b1, 1'b1, 1'b0, 1'b0, 4'hA);
    warm();
    boot(3'h1, 1'b0, 1'b0, 1'b1, 1'b0, 4'h5);
    boot(3'h1, 1'b1, 1'b1, 1'b1, 1'b1, 4'h3);
    boot(3'h5, 1'b0, 1'b1, 1'b0, 1'b0, 4'hC);
    misc();
    finish_test();
  end
endmodule : test_srs_sequencer
`default_nettype wire
